// ---- core/rtcalm_cfg.svh ----
`ifndef RTCALM_CFG_SVH
`define RTCALM_CFG_SVH

// Byte offsets of the alarm and control registers on the bus.
`define RTCALM_OFF_SECOND 8'h00
`define RTCALM_OFF_MINUTE 8'h04
`define RTCALM_OFF_HOUR 8'h08
`define RTCALM_OFF_WEEKDAY 8'h0c
`define RTCALM_OFF_DAY 8'h10
`define RTCALM_OFF_MONTH 8'h14
`define RTCALM_OFF_CTRL 8'h18

// Field positions.
`define RTCALM_BIT_ENABLE 7
`define RTCALM_BIT_FLAG 0
`define RTCALM_BIT_IRQEN 3

// Writable value bits per register; the enable bit sits above them.
`define RTCALM_MASK_SECOND 7'h7f
`define RTCALM_MASK_MINUTE 7'h7f
`define RTCALM_MASK_HOUR 7'h3f
`define RTCALM_MASK_WEEKDAY 7'h07
`define RTCALM_MASK_DAY 7'h3f
`define RTCALM_MASK_MONTH 7'h1f

// Reset values.
`define RTCALM_RST_ENABLE 1'b0
`define RTCALM_RST_FLAG 1'b0
`define RTCALM_RST_IRQEN 1'b0

// Bus answers.
`define RTCALM_RESP_OKAY 2'b00
`define RTCALM_RESP_SLVERR 2'b10

`endif

// ---- core/rtcalm_pkg.sv ----
package rtcalm_pkg;

    // Index of each alarm field in the compare array.
    typedef enum logic [2:0]
    {
        RTCALM_SEC = 3'b000,
        RTCALM_MIN = 3'b001,
        RTCALM_HOUR = 3'b010,
        RTCALM_WDAY = 3'b011,
        RTCALM_DAY = 3'b100,
        RTCALM_MON = 3'b101
    } rtcalm_field_t;

    // One alarm register: enable bit over a seven-bit BCD value.
    typedef logic [7:0] rtcalm_reg_t;

endpackage

// ---- core/rtcalm_field.sv ----
`include "rtcalm_cfg.svh"

module rtcalm_field #(
    parameter logic [6:0] VALUE_MASK = 7'h7f
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Write side.
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // Compare side.
    input wire logic [7:0] counter,
    output logic [7:0] rd_value,
    output logic field_ok
);

    logic enable_ff;
    logic [6:0] value_ff;
    logic [6:0] nxt_value;
    wire logic [6:0] cnt_bits;

    // Reserved positions are dropped on write and read back as zero.
    assign nxt_value = wr_data[6:0] & VALUE_MASK;
    assign cnt_bits = counter[6:0] & VALUE_MASK;
    assign rd_value = {enable_ff, value_ff};

    // A disabled field never blocks the match.
    assign field_ok = !enable_ff || (value_ff == cnt_bits);

    // Only the enable bit takes the reset.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enable_ff <= `RTCALM_RST_ENABLE;
        else if (wr_en)
            enable_ff <= wr_data[`RTCALM_BIT_ENABLE];
    end

    // The BCD value has no reset and survives every reset.
    always_ff @(posedge clk)
    begin
        if (wr_en)
            value_ff <= nxt_value;
    end

endmodule

// ---- core/rtcalm_top.sv ----
// What this block does
// - Eight-bit alarm registers, bit 7 enables comparing the rest.
// - Match flag sets only when every enabled alarm equals its counter.
// - Alarm values are packed BCD compared against BCD counters.
// - Minutes alarm compared when enabled; software keeps it 00 to 59.
// - Hours alarm has tens in bits 5-4, units 3-0; 00 to 23.
// - Hours and day alarm bit 6 reads zero, ignores writes.
// - Weekday alarm is a code 0 to 6 in bits 2-0.
// - Weekday alarm bits 6 to 3 read zero, ignore writes.
// - Month alarm bits 6 and 5 read zero, ignore writes.
// - Power-on reset clears every compare-enable bit.
// - Alarm values survive resets; only enable bits reset.
// - Writing 0 clears the match flag, writing 1 keeps it.
// - Alarm request is raised while flag and interrupt enable are 1.
`include "rtcalm_cfg.svh"

module rtcalm_top
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Write address channel.
    input wire logic S_AWVALID,
    output logic S_AWREADY,
    input wire logic [7:0] S_AWADDR,
    input wire logic [2:0] S_AWPROT,
    // Write data channel.
    input wire logic S_WVALID,
    output logic S_WREADY,
    input wire logic [31:0] S_WDATA,
    input wire logic [3:0] S_WSTRB,
    // Write response channel.
    output logic S_BVALID,
    input wire logic S_BREADY,
    output logic [1:0] S_BRESP,
    // Read address channel.
    input wire logic S_ARVALID,
    output logic S_ARREADY,
    input wire logic [7:0] S_ARADDR,
    input wire logic [2:0] S_ARPROT,
    // Read data channel.
    output logic S_RVALID,
    input wire logic S_RREADY,
    output logic [31:0] S_RDATA,
    output logic [1:0] S_RRESP,
    // Running BCD time counters from the clock unit.
    input wire logic [7:0] SECOND_COUNTER,
    input wire logic [7:0] MINUTE_COUNTER,
    input wire logic [7:0] HOUR_COUNTER,
    input wire logic [7:0] WEEKDAY_COUNTER,
    input wire logic [7:0] DAY_COUNTER,
    input wire logic [7:0] MONTH_COUNTER,
    // Alarm status toward the clock unit.
    output logic ALARM_MATCH_FLAG,
    output logic ALARM_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic awready_ff;
    logic wready_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic flag_ff;
    logic irqen_ff;
    logic irq_ff;
    logic match_ff;
    logic nxt_flag;
    logic [7:0] cnt_arr [6];
    logic [7:0] rd_arr [6];
    logic [5:0] ok_vec;
    logic [5:0] wr_vec;
    wire logic have_aw;
    wire logic have_w;
    wire logic do_write;
    wire logic wr_hit;
    wire logic wr_ctrl;
    wire logic wr_bad;
    wire logic do_read;
    wire logic rd_hit;
    wire logic [7:0] rd_byte;
    wire logic any_enable;
    wire logic all_match;
    wire logic match_rise;
    wire logic [7:0] ctrl_value;

    ////////////////////////////////////////////////////////////////////////
    // Alarm field bank.

    // Counter inputs sorted by field index.
    assign cnt_arr[rtcalm_pkg::RTCALM_SEC] = SECOND_COUNTER;
    assign cnt_arr[rtcalm_pkg::RTCALM_MIN] = MINUTE_COUNTER;
    assign cnt_arr[rtcalm_pkg::RTCALM_HOUR] = HOUR_COUNTER;
    assign cnt_arr[rtcalm_pkg::RTCALM_WDAY] = WEEKDAY_COUNTER;
    assign cnt_arr[rtcalm_pkg::RTCALM_DAY] = DAY_COUNTER;
    assign cnt_arr[rtcalm_pkg::RTCALM_MON] = MONTH_COUNTER;

    // Per-field write strobes decoded from the captured address.
    assign wr_vec[0] = wr_hit && awaddr_ff == `RTCALM_OFF_SECOND;
    assign wr_vec[1] = wr_hit && awaddr_ff == `RTCALM_OFF_MINUTE;
    assign wr_vec[2] = wr_hit && awaddr_ff == `RTCALM_OFF_HOUR;
    assign wr_vec[3] = wr_hit && awaddr_ff == `RTCALM_OFF_WEEKDAY;
    assign wr_vec[4] = wr_hit && awaddr_ff == `RTCALM_OFF_DAY;
    assign wr_vec[5] = wr_hit && awaddr_ff == `RTCALM_OFF_MONTH;

    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_SECOND)) u_second
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[0]), .wr_data(wdata_ff),
        .counter(cnt_arr[0]), .rd_value(rd_arr[0]), .field_ok(ok_vec[0])
    );
    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_MINUTE)) u_minute
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[1]), .wr_data(wdata_ff),
        .counter(cnt_arr[1]), .rd_value(rd_arr[1]), .field_ok(ok_vec[1])
    );
    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_HOUR)) u_hour
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[2]), .wr_data(wdata_ff),
        .counter(cnt_arr[2]), .rd_value(rd_arr[2]), .field_ok(ok_vec[2])
    );
    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_WEEKDAY)) u_weekday
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[3]), .wr_data(wdata_ff),
        .counter(cnt_arr[3]), .rd_value(rd_arr[3]), .field_ok(ok_vec[3])
    );
    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_DAY)) u_day
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[4]), .wr_data(wdata_ff),
        .counter(cnt_arr[4]), .rd_value(rd_arr[4]), .field_ok(ok_vec[4])
    );
    rtcalm_field #(.VALUE_MASK(`RTCALM_MASK_MONTH)) u_month
    (
        .clk(CLK_SYS), .rst(RST), .wr_en(wr_vec[5]), .wr_data(wdata_ff),
        .counter(cnt_arr[5]), .rd_value(rd_arr[5]), .field_ok(ok_vec[5])
    );

    ////////////////////////////////////////////////////////////////////////
    // Match detection and alarm flag.

    // The compare needs at least one enabled field to count as a match.
    assign any_enable = rd_arr[0][7] | rd_arr[1][7] | rd_arr[2][7]
        | rd_arr[3][7] | rd_arr[4][7] | rd_arr[5][7];
    assign all_match = any_enable && (&ok_vec);
    // The flag sets on the first cycle of a match, not while it lasts,
    // so a clear by software during the matching second sticks.
    assign match_rise = all_match && !match_ff;

    // Writing 0 clears, writing 1 keeps; a new match beats the clear.
    assign nxt_flag = match_rise ? 1'b1 :
        (wr_ctrl && !wdata_ff[`RTCALM_BIT_FLAG]) ? 1'b0 : flag_ff;

    // Match history and the flag.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            match_ff <= 1'b0;
            flag_ff <= `RTCALM_RST_FLAG;
        end
        else
        begin
            match_ff <= all_match;
            flag_ff <= nxt_flag;
        end
    end

    // Interrupt enable and the registered request.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            irqen_ff <= `RTCALM_RST_IRQEN;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                irqen_ff <= wdata_ff[`RTCALM_BIT_IRQEN];
            irq_ff <= nxt_flag && (wr_ctrl ? wdata_ff[`RTCALM_BIT_IRQEN]
                : irqen_ff);
        end
    end

    assign ALARM_MATCH_FLAG = flag_ff;
    assign ALARM_IRQ = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus write path.

    // A write goes ahead once address and data are both held.
    assign have_aw = !awready_ff;
    assign have_w = !wready_ff;
    assign do_write = have_aw && have_w && !bvalid_ff;
    assign wr_hit = do_write && wstrb0_ff;
    assign wr_ctrl = wr_hit && awaddr_ff == `RTCALM_OFF_CTRL;
    // Anything past the control word or off a word boundary is refused.
    assign wr_bad = awaddr_ff > `RTCALM_OFF_CTRL || awaddr_ff[1:0] != 2'b00;

    // Address and data are caught independently; ready drops once held.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end
        else
        begin
            if (S_AWVALID && awready_ff)
            begin
                awready_ff <= 1'b0;
                awaddr_ff <= S_AWADDR;
            end
            else if (do_write)
                awready_ff <= 1'b1;
            if (S_WVALID && wready_ff)
            begin
                wready_ff <= 1'b0;
                wdata_ff <= S_WDATA[7:0];
                wstrb0_ff <= S_WSTRB[0];
            end
            else if (do_write)
                wready_ff <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer SLVERR.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RTCALM_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_bad ? `RTCALM_RESP_SLVERR : `RTCALM_RESP_OKAY;
        end
        else if (S_BREADY)
            bvalid_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus read path.

    // Read decode works on the live address; the reply is registered.
    assign do_read = S_ARVALID && arready_ff;
    assign rd_hit = S_ARADDR[1:0] == 2'b00 && S_ARADDR <= `RTCALM_OFF_CTRL;
    assign ctrl_value = {4'h0, irqen_ff, 2'b00, flag_ff};
    assign rd_byte = (S_ARADDR == `RTCALM_OFF_CTRL) ? ctrl_value
        : rd_hit ? rd_arr[S_ARADDR[4:2]] : 8'h00;

    // One read at a time; the address is refused while data waits.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RTCALM_RESP_OKAY;
        end
        else if (do_read)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_hit ? `RTCALM_RESP_OKAY : `RTCALM_RESP_SLVERR;
        end
        else if (rvalid_ff && S_RREADY)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign S_AWREADY = awready_ff;
    assign S_WREADY = wready_ff;
    assign S_BVALID = bvalid_ff;
    assign S_BRESP = bresp_ff;
    assign S_ARREADY = arready_ff;
    assign S_RVALID = rvalid_ff;
    assign S_RDATA = rdata_ff;
    assign S_RRESP = rresp_ff;

endmodule

// ---- bench/rtcalm_chk.sv ----
module rtcalm_chk
(
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Read channels.
    input wire logic S_ARVALID,
    input wire logic S_ARREADY,
    input wire logic [7:0] S_ARADDR,
    input wire logic S_RVALID,
    input wire logic S_RREADY,
    input wire logic [31:0] S_RDATA,
    // Write response channel.
    input wire logic S_BVALID,
    input wire logic S_BREADY,
    input wire logic [1:0] S_BRESP,
    // Alarm outputs.
    input wire logic ALARM_MATCH_FLAG,
    input wire logic ALARM_IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ra_ff;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // Remembers the address of the read under way.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            ra_ff <= 8'h00;
        else if (S_ARVALID && S_ARREADY)
            ra_ff <= S_ARADDR;
    end

    a_irq_needs_flag: assert property (
        ALARM_IRQ |-> ALARM_MATCH_FLAG) else $error("Request without flag.");
    a_rdata_narrow: assert property (
        S_RVALID |-> S_RDATA[31:8] == 24'h0) else $error("Upper data set.");
    a_read_answer: assert property (
        S_ARVALID && S_ARREADY |=> S_RVALID) else $error("Read not answered.");
    a_read_holds: assert property (
        S_RVALID && !S_RREADY |=> S_RVALID && $stable(S_RDATA))
        else $error("Read data dropped.");
    a_resp_holds: assert property (
        S_BVALID && !S_BREADY |=> S_BVALID && $stable(S_BRESP))
        else $error("Write response dropped.");
    a_flag_clear: assert property (
        $fell(ALARM_MATCH_FLAG) |-> $rose(S_BVALID))
        else $error("Flag fell without a write.");
    a_bit6_zero: assert property (
        S_RVALID && (ra_ff == 8'h08 || ra_ff == 8'h10) |-> !S_RDATA[6])
        else $error("Bit 6 reads one.");
    a_wday_zero: assert property (
        S_RVALID && ra_ff == 8'h0c |-> S_RDATA[6:3] == 4'h0)
        else $error("Weekday reserved bits set.");
    a_month_zero: assert property (
        S_RVALID && ra_ff == 8'h14 |-> S_RDATA[6:5] == 2'h0)
        else $error("Month reserved bits set.");
endmodule

bind rtcalm_top rtcalm_chk i_rtcalm_chk
(
    .CLK_SYS(CLK_SYS), .RST(RST), .S_ARVALID(S_ARVALID),
    .S_ARREADY(S_ARREADY), .S_ARADDR(S_ARADDR), .S_RVALID(S_RVALID),
    .S_RREADY(S_RREADY), .S_RDATA(S_RDATA), .S_BVALID(S_BVALID),
    .S_BREADY(S_BREADY), .S_BRESP(S_BRESP),
    .ALARM_MATCH_FLAG(ALARM_MATCH_FLAG), .ALARM_IRQ(ALARM_IRQ)
);

// ---- bench/test_rtcalm_top.sv ----
module test_rtcalm_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, wbyte = 8'h00;
    logic [7:0] cnt [6] = '{default: 8'h00};
    wire logic awready, wready, bvalid, arready, rvalid, flag, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic [31:0] d;
    logic [1:0] r;
    int n_fail = 0;
    int checks_done = 0;
    logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    // Legal values; reserved bits are set on purpose to prove they drop.
    logic [7:0] wr_val [6] = '{8'hd9, 8'hd9, 8'he3, 8'hfe, 8'hf1, 8'hf2};
    logic [7:0] exp_rd [6] = '{8'hd9, 8'hd9, 8'ha3, 8'h86, 8'hb1, 8'h92};

    rtcalm_top i_rtcalm_top
    (
        .CLK_SYS(clk), .RST(rst), .S_AWVALID(awvalid), .S_AWREADY(awready),
        .S_AWADDR(awaddr), .S_AWPROT(3'h0), .S_WVALID(wvalid),
        .S_WREADY(wready), .S_WDATA({24'h000000, wbyte}), .S_WSTRB(4'h1),
        .S_BVALID(bvalid), .S_BREADY(bready), .S_BRESP(bresp),
        .S_ARVALID(arvalid), .S_ARREADY(arready), .S_ARADDR(araddr),
        .S_ARPROT(3'h0), .S_RVALID(rvalid), .S_RREADY(rready),
        .S_RDATA(rdata), .S_RRESP(rresp), .SECOND_COUNTER(cnt[0]),
        .MINUTE_COUNTER(cnt[1]), .HOUR_COUNTER(cnt[2]),
        .WEEKDAY_COUNTER(cnt[3]), .DAY_COUNTER(cnt[4]),
        .MONTH_COUNTER(cnt[5]), .ALARM_MATCH_FLAG(flag), .ALARM_IRQ(irq)
    );

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h want %h", $time, got, want);
        end
    endtask

    // One write; bready stands from the start until bvalid is sampled.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int i;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wbyte <= v;
        bready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        if (i == 40)
        begin
            n_fail++;
            summarize();
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    // One read; rready stands from the start until rvalid is sampled.
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        if (i == 40)
        begin
            n_fail++;
            summarize();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Lets registered alarm outputs settle.
    task automatic w3();
        repeat (3) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: row table first, then reset, compare and bus faults.
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            wr(adr[k], wr_val[k]);
            chk(r, 2'b00);
            rd(adr[k]);
            chk(d, exp_rd[k]);
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            rd(adr[k]);
            chk(d, exp_rd[k] & 8'h7f);
        end
        cnt <= '{default: 8'hff};
        w3();
        chk(flag, 1'b0);
        wr(8'h00, 8'hc5);
        wr(8'h04, 8'hb0);
        wr(8'h08, 8'ha3);
        wr(8'h18, 8'h08);
        cnt[0] <= 8'h45;
        cnt[1] <= 8'h31;
        cnt[2] <= 8'h23;
        w3();
        chk(flag, 1'b0);
        @(posedge clk);
        cnt[1] <= 8'h30;
        cnt[2] <= 8'h17;
        w3();
        chk(flag, 1'b0);
        @(posedge clk);
        cnt[2] <= 8'h23;
        w3();
        chk(flag, 1'b1);
        chk(irq, 1'b1);
        @(posedge clk);
        cnt[0] <= 8'h46;
        wr(8'h18, 8'h09);
        w3();
        chk(flag, 1'b1);
        wr(8'h18, 8'h00);
        w3();
        chk(flag, 1'b0);
        chk(irq, 1'b0);
        @(posedge clk);
        cnt[0] <= 8'h45;
        w3();
        chk(flag, 1'b1);
        chk(irq, 1'b0);
        wr(8'h0c, 8'h86);
        wr(8'h10, 8'h91);
        wr(8'h14, 8'h92);
        wr(8'h18, 8'h00);
        w3();
        chk(flag, 1'b0);
        @(posedge clk);
        cnt[3] <= 8'h06;
        cnt[4] <= 8'h11;
        cnt[5] <= 8'h11;
        w3();
        chk(flag, 1'b0);
        @(posedge clk);
        cnt[5] <= 8'h12;
        w3();
        chk(flag, 1'b1);
        rd(8'h1c);
        chk(r, 2'b10);
        chk(d, 32'h0);
        wr(8'h1c, 8'h00);
        chk(r, 2'b10);
        summarize();
    end

    // Cuts a hung run short.
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule
